// file: hdl/sckpm_top.sv
`timescale 1ns/1ps
// system clock selection and power mode control
module sckpm_top
    import sckpm_pkg::*;
#(
    parameter int STABLE_TICKS = 16  // oscillator ticks until flagged stable
)(
    // clock and reset
    input  wire logic              I_REF_CLK,
    input  wire logic              I_RESETN,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
    input  wire logic              I_AVS_READ,
    input  wire logic              I_AVS_WRITE,
    input  wire logic [31:0]       I_AVS_WRITEDATA,
    input  wire logic [3:0]        I_AVS_BYTEENABLE,
    output logic      [31:0]       O_AVS_READDATA,
    output logic                   O_AVS_WAITREQUEST,
    // cpu side
    input  wire logic              I_HALT,        // halt completes, one pulse
    input  wire logic              I_WAKE,        // wake-up event, one pulse
    input  wire logic              I_WDT_ENABLE,  // watchdog function on
    // raw oscillator outputs
    input  wire logic              I_FAST_RC_OSC,
    input  wire logic              I_FAST_XTAL_OSC,
    input  wire logic              I_SLOW_XTAL_OSC,
    input  wire logic              I_SLOW_RC_OSC,
    // oscillator controls
    output logic                   O_FAST_RC_ON,
    output logic      [1:0]        O_FAST_RC_FREQ,
    output logic                   O_FAST_XTAL_ON,
    output logic                   O_FAST_XTAL_RANGE,
    output logic                   O_SLOW_XTAL_ON,
    output logic                   O_SLOW_XTAL_SPEEDUP,
    output logic                   O_SLOW_RC_ON,
    // clock enables and status
    output logic                   O_SYSTEM_CLOCK_EN,
    output logic                   O_HIGH_SPEED_CLOCK_EN,
    output logic                   O_LOW_SPEED_CLOCK_EN,
    output logic                   O_CPU_RUN,
    output logic      [2:0]        O_MODE,
    output logic                   O_SWITCH_BUSY
);

    localparam int CW = $clog2(STABLE_TICKS + 1);  // stable counter width

    // a zero count would flag an oscillator stable before it ticks
    if (STABLE_TICKS < 1) begin : g_bad_stable
        $error("STABLE_TICKS must be at least one");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sckpm_cfg_s  tgt;       // written selection
        sckpm_cfg_s  cur;       // selection in force
        logic        hidle;     // high_osc_idle_enable
        logic        lidle;     // low_osc_idle_enable
        logic [1:0]  rc_freq;   // fast_rc_freq_select
        logic        rc_en;     // fast_rc_enable
        logic        rc_flag;   // fast_rc_stable_flag
        logic        xh_range;  // fast_crystal_range
        logic        xh_en;     // fast_crystal_enable
        logic        xh_flag;   // fast_crystal_stable_flag
        logic        xl_spd;    // slow_crystal_speedup
        logic        xl_en;     // slow_crystal_enable
        logic        xl_flag;   // slow_crystal_stable_flag
        logic [CW-1:0] rc_cnt;  // settling counters
        logic [CW-1:0] xh_cnt;
        logic [CW-1:0] xl_cnt;
        logic [3:0]  s1;        // pin synchroniser stages
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [3:0]  lvl;       // filtered oscillator levels
        logic [2:0]  sw_cnt;    // old clock periods seen
        logic        sw_busy;   // selection change pending
        sckpm_mode_e mode;      // operating mode
        logic        ack;       // bus answer cycle
        logic [7:0]  rdata;     // read data
        logic        sys_en;    // system clock enable
        logic        hi_en;     // high clock enable
        logic        lo_en;     // low clock enable
        logic [3:0]  osc_on;    // oscillator run controls
    } sckpm_state_s;

    sckpm_state_s st_q;  // registered state
    sckpm_state_s st_d;  // next state

    logic       div_pulse;    // divided high clock
    logic [3:0] tick;         // one pulse per oscillator period
    logic       hi_tick;      // selected high source tick
    logic       lo_tick;      // selected low source tick
    logic       src_tick;     // current system source tick
    logic       tgt_tick;     // target source tick
    logic       bus_req;      // read or write pending
    logic       bus_take;     // request answered this cycle
    logic       run;          // cpu running
    logic       hi_allowed;   // mode lets high oscillators run
    logic       hi_needed;    // high clock feeds a consumer
    logic       lo_on;        // low clock on
    logic       sys_allowed;  // mode lets the system clock run

    // one settling step: restart clears, ticks count up to the flag
    function automatic logic [CW:0] settle(input logic on, input logic restart,
                                           input logic tk, input logic [CW-1:0] cnt);
        logic [CW-1:0] c;
        c = cnt;
        if (!on || restart) begin
            c = '0;
        end else if (tk && c != CW'(STABLE_TICKS)) begin
            c = CW'(c + 1'b1);
        end
        settle = {c == CW'(STABLE_TICKS), c};
    endfunction : settle

    // tick of the high source named by a select bit
    function automatic logic pick_high(input logic hsel, input logic [3:0] t);
        pick_high = hsel ? t[OSC_FAST_XTAL] : t[OSC_FAST_RC];
    endfunction : pick_high

    // tick of the low source named by a select bit
    function automatic logic pick_low(input logic lsel, input logic [3:0] t);
        pick_low = lsel ? t[OSC_SLOW_XTAL] : t[OSC_SLOW_RC];
    endfunction : pick_low

    // ------------------------------------------------------------
    // source ticks and mode decode
    // ------------------------------------------------------------
    // a tick only counts while its oscillator is commanded on
    assign tick = ~st_q.lvl & st_q.s2 & st_q.s3 & st_q.osc_on;
    assign hi_tick = pick_high(st_q.cur.hsel, tick);
    assign lo_tick = pick_low(st_q.cur.lsel, tick);
    // low clock for 111, divided high otherwise
    assign src_tick = (st_q.cur.sel == SEL_LOW_CLK) ? lo_tick : div_pulse;
    assign tgt_tick = (st_q.tgt.sel == SEL_LOW_CLK) ? pick_low(st_q.tgt.lsel, tick)
                                                     : pick_high(st_q.tgt.hsel, tick);

    assign run = (st_q.mode == MODE_FAST) || (st_q.mode == MODE_SLOW);
    // run modes, idle_low_only and idle_both_osc keep the low clock
    assign lo_on = run || (st_q.mode == MODE_IDLE_LOW) || (st_q.mode == MODE_IDLE_BOTH);
    assign hi_allowed = run || (st_q.mode == MODE_IDLE_BOTH) || (st_q.mode == MODE_IDLE_HIGH);
    // in slow mode only the enable bit keeps the high oscillator
    assign hi_needed = (st_q.mode == MODE_FAST) || (st_q.mode == MODE_IDLE_BOTH)
                    || (st_q.mode == MODE_IDLE_HIGH);

    // system clock gating per mode
    always_comb begin
        unique case (st_q.mode)
            MODE_FAST, MODE_SLOW, MODE_IDLE_BOTH: sys_allowed = 1'b1;
            // runs only on the low clock
            MODE_IDLE_LOW:  sys_allowed = (st_q.cur.sel == SEL_LOW_CLK);
            // runs only on the high clock
            MODE_IDLE_HIGH: sys_allowed = (st_q.cur.sel != SEL_LOW_CLK);
            MODE_SLEEP:     sys_allowed = 1'b0;
            default:        sys_allowed = 1'b0;
        endcase
    end

    sckpm_divider u_div (
        .i_clk     (I_REF_CLK),
        .i_resetn  (I_RESETN),
        .i_tick    (hi_tick),
        .i_ratio   (st_q.cur.sel),
        .i_restart ((st_q.tgt != st_q.cur) && (st_q.sw_cnt == SWITCH_PULSES) && tgt_tick),
        .o_pulse   (div_pulse)
    );

    assign bus_req  = I_AVS_READ || I_AVS_WRITE;
    assign bus_take = bus_req && st_q.ack;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [CW:0] stp;
        logic        sel_low_xtal;
        st_d = st_q;
        stp  = '0;
        sel_low_xtal = (st_q.cur.sel == SEL_LOW_CLK) && st_q.cur.lsel;

        // three-stage pin sync; level changes once stages two and three agree
        st_d.s1 = {I_SLOW_RC_OSC, I_SLOW_XTAL_OSC, I_FAST_XTAL_OSC, I_FAST_RC_OSC};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 | st_q.s3));

        // bus: one wait cycle, answer on the second edge
        st_d.ack = bus_req && !st_q.ack;
        if (st_d.ack && I_AVS_READ) begin
            // four byte-wide registers, unused bits zero
            unique case (I_AVS_ADDRESS)
                OFS_SYS_CLK:   st_d.rdata = {st_q.tgt.sel, 1'b0, st_q.tgt.hsel,
                                             st_q.tgt.lsel, st_q.hidle, st_q.lidle};
                OFS_FAST_RC:   st_d.rdata = {4'h0, st_q.rc_freq, st_q.rc_flag, st_q.rc_en};
                OFS_FAST_XTAL: st_d.rdata = {5'h00, st_q.xh_range, st_q.xh_flag, st_q.xh_en};
                OFS_SLOW_XTAL: st_d.rdata = {5'h00, st_q.xl_spd, st_q.xl_flag, st_q.xl_en};
                default:       st_d.rdata = 8'h00;  // unmapped reads zero
            endcase
        end

        // writes land on the edge that ends the wait
        if (bus_take && I_AVS_WRITE && I_AVS_BYTEENABLE[0]) begin
            unique case (I_AVS_ADDRESS)
                OFS_SYS_CLK: begin
                    st_d.tgt.sel  = I_AVS_WRITEDATA[SEL_MSB:SEL_LSB];
                    st_d.tgt.hsel = I_AVS_WRITEDATA[HSEL_BIT];
                    st_d.tgt.lsel = I_AVS_WRITEDATA[LSEL_BIT];
                    st_d.hidle    = I_AVS_WRITEDATA[HIDLE_BIT];
                    st_d.lidle    = I_AVS_WRITEDATA[LIDLE_BIT];
                end
                OFS_FAST_RC: begin
                    st_d.rc_freq = I_AVS_WRITEDATA[FREQ_MSB:FREQ_LSB];
                    st_d.rc_en   = I_AVS_WRITEDATA[EN_BIT];
                end
                OFS_FAST_XTAL: begin
                    // range is frozen while the crystal is enabled
                    if (!st_q.xh_en) begin
                        st_d.xh_range = I_AVS_WRITEDATA[OPT_BIT];
                    end
                    st_d.xh_en = I_AVS_WRITEDATA[EN_BIT];
                end
                OFS_SLOW_XTAL: begin
                    // speed-up is frozen once the crystal clocks the system
                    if (!sel_low_xtal) begin
                        st_d.xl_spd = I_AVS_WRITEDATA[OPT_BIT];
                    end
                    st_d.xl_en = I_AVS_WRITEDATA[EN_BIT];
                end
                default: ;  // unmapped writes ignored
            endcase
        end

        // clear on enable or frequency change, set after settling
        stp = settle(st_q.osc_on[OSC_FAST_RC],
                     (st_d.rc_en && !st_q.rc_en) || (st_d.rc_freq != st_q.rc_freq),
                     tick[OSC_FAST_RC], st_q.rc_cnt);
        st_d.rc_cnt  = stp[CW-1:0];
        st_d.rc_flag = stp[CW];
        stp = settle(st_q.osc_on[OSC_FAST_XTAL], st_d.xh_en && !st_q.xh_en,
                     tick[OSC_FAST_XTAL], st_q.xh_cnt);
        st_d.xh_cnt  = stp[CW-1:0];
        st_d.xh_flag = stp[CW];
        stp = settle(st_q.osc_on[OSC_SLOW_XTAL], st_d.xl_en && !st_q.xl_en,
                     tick[OSC_SLOW_XTAL], st_q.xl_cnt);
        st_d.xl_cnt  = stp[CW-1:0];
        st_d.xl_flag = stp[CW];

        // count whole old periods, then change on a target tick edge
        if (st_q.tgt != st_q.cur) begin
            st_d.sw_busy = 1'b1;
            if (st_q.sw_cnt != SWITCH_PULSES) begin
                if (src_tick) begin
                    st_d.sw_cnt = 3'(st_q.sw_cnt + 3'h1);
                end
            end else if (tgt_tick) begin
                st_d.cur    = st_q.tgt;
                st_d.sw_cnt = 3'h0;
            end
        end else begin
            st_d.sw_busy = 1'b0;
            st_d.sw_cnt  = 3'h0;
        end

        // operating mode
        unique case (st_q.mode)
            MODE_FAST, MODE_SLOW: begin
                // idle bits sampled as the halt completes
                if (I_HALT) begin
                    unique case ({st_q.hidle, st_q.lidle})
                        2'b00: st_d.mode = MODE_SLEEP;
                        2'b01: st_d.mode = MODE_IDLE_LOW;
                        2'b10: st_d.mode = MODE_IDLE_HIGH;
                        2'b11: st_d.mode = MODE_IDLE_BOTH;
                    endcase
                end else begin
                    st_d.mode = (st_q.cur.sel == SEL_LOW_CLK) ? MODE_SLOW : MODE_FAST;
                end
            end
            default: begin
                // halted until a wake-up event
                if (I_WAKE) begin
                    st_d.mode = (st_q.cur.sel == SEL_LOW_CLK) ? MODE_SLOW : MODE_FAST;
                end
            end
        endcase

        // enable bit or need keeps a high oscillator on
        st_d.osc_on[OSC_FAST_RC] = hi_allowed
            && (st_q.rc_en || (hi_needed && !st_q.cur.hsel));
        st_d.osc_on[OSC_FAST_XTAL] = hi_allowed
            && (st_q.xh_en || (hi_needed && st_q.cur.hsel));
        st_d.osc_on[OSC_SLOW_XTAL] = lo_on && (st_q.xl_en || st_q.cur.lsel);
        // slow rc stops in sleep unless the watchdog runs
        st_d.osc_on[OSC_SLOW_RC] = (st_q.mode != MODE_SLEEP) || I_WDT_ENABLE;

        // clock enables, one reference-cycle pulse per source period
        st_d.hi_en  = hi_tick && hi_allowed;
        st_d.lo_en  = lo_tick && lo_on;
        st_d.sys_en = src_tick && sys_allowed;
    end

    // state register
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st_q          <= '0;
            st_q.tgt      <= {RST_SYS_CLK[SEL_MSB:SEL_LSB], RST_SYS_CLK[HSEL_BIT],
                              RST_SYS_CLK[LSEL_BIT]};
            st_q.cur      <= {RST_SYS_CLK[SEL_MSB:SEL_LSB], RST_SYS_CLK[HSEL_BIT],
                              RST_SYS_CLK[LSEL_BIT]};
            st_q.hidle    <= RST_SYS_CLK[HIDLE_BIT];
            st_q.lidle    <= RST_SYS_CLK[LIDLE_BIT];
            st_q.rc_freq  <= RST_FAST_RC[FREQ_MSB:FREQ_LSB];
            st_q.rc_en    <= RST_FAST_RC[EN_BIT];
            st_q.xh_range <= RST_FAST_XTAL[OPT_BIT];
            st_q.xh_en    <= RST_FAST_XTAL[EN_BIT];
            st_q.xl_spd   <= RST_SLOW_XTAL[OPT_BIT];
            st_q.xl_en    <= RST_SLOW_XTAL[EN_BIT];
            st_q.mode     <= MODE_FAST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_AVS_WAITREQUEST     = bus_req && !st_q.ack;
    assign O_AVS_READDATA        = {24'h000000, st_q.rdata};
    assign O_FAST_RC_ON          = st_q.osc_on[OSC_FAST_RC];
    assign O_FAST_RC_FREQ        = st_q.rc_freq;
    assign O_FAST_XTAL_ON        = st_q.osc_on[OSC_FAST_XTAL];
    assign O_FAST_XTAL_RANGE     = st_q.xh_range;
    assign O_SLOW_XTAL_ON        = st_q.osc_on[OSC_SLOW_XTAL];
    assign O_SLOW_XTAL_SPEEDUP   = st_q.xl_spd;
    assign O_SLOW_RC_ON          = st_q.osc_on[OSC_SLOW_RC];
    assign O_SYSTEM_CLOCK_EN     = st_q.sys_en;
    assign O_HIGH_SPEED_CLOCK_EN = st_q.hi_en;
    assign O_LOW_SPEED_CLOCK_EN  = st_q.lo_en;
    assign O_CPU_RUN             = run;
    assign O_MODE                = st_q.mode;
    assign O_SWITCH_BUSY         = st_q.sw_busy;

endmodule : sckpm_top

// file: include/sckpm_pkg.sv
// Notes on behaviour
// - select field picks divided high or low clock
// - high clock from fast crystal or fast rc
// - low clock from slow crystal or slow rc
// - fast mode divides high clock by 1..64
// - leaving high clock, its enable bit decides
// - six modes, run modes keep low clocks on
// - slow mode runs cpu from low clock
// - halt with both idle bits clear sleeps
// - sleep keeps slow rc only with watchdog
// - idle_low_only keeps low clock, sysclk if 111
// - idle_both_osc keeps every clock running
// - idle_high_only keeps high clock, sysclk unless 111
// - four 8-bit control registers
// - high select 0 rc, 1 crystal
// - low select 0 rc, 1 crystal
// - stable flag clears, sets after settling
package sckpm_pkg;

    // ------------------------------------------------------------
    // register map, word index on the bus
    // ------------------------------------------------------------
    localparam int         ADDR_W        = 3;
    localparam logic [2:0] OFS_SYS_CLK   = 3'h0;  // system_clock_control
    localparam logic [2:0] OFS_FAST_RC   = 3'h1;  // internal_fast_rc_control
    localparam logic [2:0] OFS_FAST_XTAL = 3'h2;  // fast_crystal_control
    localparam logic [2:0] OFS_SLOW_XTAL = 3'h3;  // slow_crystal_control

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SEL_MSB   = 7;  // sysclk_select
    localparam int SEL_LSB   = 5;
    localparam int HSEL_BIT  = 3;  // high_osc_select
    localparam int LSEL_BIT  = 2;  // low_osc_select
    localparam int HIDLE_BIT = 1;  // high_osc_idle_enable
    localparam int LIDLE_BIT = 0;  // low_osc_idle_enable
    localparam int FREQ_MSB  = 3;  // fast_rc_freq_select
    localparam int FREQ_LSB  = 2;
    localparam int OPT_BIT   = 2;  // crystal range / speedup
    localparam int FLAG_BIT  = 1;  // stable flag
    localparam int EN_BIT    = 0;  // oscillator enable

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SYS_CLK   = 8'h00;
    localparam logic [7:0] RST_FAST_RC   = 8'h01;
    localparam logic [7:0] RST_FAST_XTAL = 8'h00;
    localparam logic [7:0] RST_SLOW_XTAL = 8'h00;
    localparam logic [2:0] SEL_LOW_CLK   = 3'h7;  // code picking the low clock
    localparam logic [2:0] SWITCH_PULSES = 3'h4;  // old clock periods before a switch

    // oscillator pin index
    localparam int OSC_FAST_RC   = 0;
    localparam int OSC_FAST_XTAL = 1;
    localparam int OSC_SLOW_XTAL = 2;
    localparam int OSC_SLOW_RC   = 3;

    // operating modes
    typedef enum logic [2:0] {
        MODE_FAST      = 3'b000,
        MODE_SLOW      = 3'b001,
        MODE_SLEEP     = 3'b010,
        MODE_IDLE_LOW  = 3'b011,  // idle_low_only
        MODE_IDLE_BOTH = 3'b100,  // idle_both_osc
        MODE_IDLE_HIGH = 3'b101   // idle_high_only
    } sckpm_mode_e;

    // clock source selection carried together
    typedef struct packed {
        logic [2:0] sel;   // sysclk_select
        logic       hsel;  // high_osc_select
        logic       lsel;  // low_osc_select
    } sckpm_cfg_s;

endpackage : sckpm_pkg

// file: hdl/sckpm_divider.sv
`timescale 1ns/1ps
// power-of-two divider on a tick stream, output pulse registered
module sckpm_divider
    import sckpm_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // control
    input  wire logic       i_tick,     // source tick
    input  wire logic [2:0] i_ratio,    // divide by 2**i_ratio, by 64 for code 7
    input  wire logic       i_restart,  // realign phase
    // output
    output logic            o_pulse
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] cnt;    // ticks seen this period
        logic       pulse;  // divided tick
    } sckpm_div_s;

    sckpm_div_s st_q;  // registered state
    sckpm_div_s st_d;  // next state

    // mask of the count bits for a ratio code
    function automatic logic [5:0] ratio_mask(input logic [2:0] r);
        logic [6:0] one;
        one        = 7'h01 << r;
        ratio_mask = 6'(one - 7'h01);
    endfunction : ratio_mask

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d       = st_q;
        st_d.pulse = 1'b0;
        // restart puts the pulse on a whole-period boundary
        if (i_restart) begin
            st_d.cnt = 6'h00;
        end else if (i_tick) begin
            if (st_q.cnt == ratio_mask(i_ratio)) begin
                st_d.cnt   = 6'h00;
                st_d.pulse = 1'b1;
            end else begin
                st_d.cnt = 6'(st_q.cnt + 6'h01);
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_pulse = st_q.pulse;

endmodule : sckpm_divider

// file: tb/sckpm_osc_model.sv
`timescale 1ns/1ps
// oscillator stand-in, stops low while disabled
module sckpm_osc_model #(
    parameter int HALF = 20  // half period in ns
)(
    input  wire logic i_on,  // enable from the block
    output logic      o_osc  // raw level
);
    initial begin
        o_osc = 1'b0;
        forever #HALF o_osc = i_on ? ~o_osc : 1'b0;
    end
endmodule : sckpm_osc_model

// file: tb/sckpm_top_props.sv
`timescale 1ns/1ps
// port checks; [*3] lets _ON outputs trail a mode change
module sckpm_props
    import sckpm_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic I_HALT,
    input wire logic I_WAKE,
    input wire logic I_WDT_ENABLE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_FAST_RC_ON,
    input wire logic O_FAST_XTAL_ON,
    input wire logic O_SLOW_RC_ON,
    input wire logic O_SYSTEM_CLOCK_EN,
    input wire logic O_HIGH_SPEED_CLOCK_EN,
    input wire logic O_LOW_SPEED_CLOCK_EN,
    input wire logic O_CPU_RUN,
    input wire logic [2:0] O_MODE
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);
    AST_WAIT: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |-> O_AVS_WAITREQUEST
        ##1 !O_AVS_WAITREQUEST) else $error("wait state count wrong");
    AST_RDATA: assert property (I_AVS_READ && !O_AVS_WAITREQUEST |->
        O_AVS_READDATA[31:8] == 24'h0) else $error("upper read bits set");
    AST_RUN: assert property (O_CPU_RUN[*3] |-> O_SLOW_RC_ON)
        else $error("slow rc off while running");
    AST_HALT: assert property (I_HALT && O_CPU_RUN |=> !O_CPU_RUN)
        else $error("halt ignored");
    AST_SLEEP: assert property ((O_MODE == MODE_SLEEP)[*3] |-> !O_FAST_RC_ON
        && !O_FAST_XTAL_ON && !O_SYSTEM_CLOCK_EN && !O_LOW_SPEED_CLOCK_EN)
        else $error("clock alive in sleep");
    AST_WDT: assert property ((O_MODE == MODE_SLEEP && $stable(I_WDT_ENABLE))[*3]
        |-> O_SLOW_RC_ON == I_WDT_ENABLE) else $error("slow rc vs watchdog");
    AST_IDLE_LOW: assert property ((O_MODE == MODE_IDLE_LOW)[*3] |->
        !O_HIGH_SPEED_CLOCK_EN && !O_FAST_RC_ON) else $error("high clock in idle low");
    AST_IDLE_BOTH: assert property ((O_MODE == MODE_IDLE_BOTH)[*3] |->
        O_FAST_RC_ON || O_FAST_XTAL_ON) else $error("high osc off in idle both");
    AST_IDLE_HIGH: assert property ((O_MODE == MODE_IDLE_HIGH)[*3] |->
        !O_LOW_SPEED_CLOCK_EN) else $error("low clock in idle high");
endmodule : sckpm_props
bind sckpm_top sckpm_props i_sckpm_props (.*);

// file: tb/sckpm_top_test.sv
`timescale 1ns/1ps
module sckpm_top_test;
    import sckpm_pkg::*;
    logic clk, rstn, rd, wr, halt, wake, wdt, wreq, busy, cpu, sys_en, rng, spd;
    logic [1:0] frq;
    logic [2:0] adr, mode;
    logic [31:0] wd, q, rdata;
    logic [3:0] osc, on;
    int n_fail, n_tests, k;
    logic [7:0] rst_v[4] = '{RST_SYS_CLK, RST_FAST_RC, RST_FAST_XTAL, RST_SLOW_XTAL};
    sckpm_mode_e exp_m[4] = '{MODE_SLEEP, MODE_IDLE_LOW, MODE_IDLE_HIGH, MODE_IDLE_BOTH};
    for (genvar g = 0; g < 4; g++) begin : g_osc
        sckpm_osc_model #(.HALF(20 + 20 * g)) i_sckpm_osc_model (.i_on(on[g]), .o_osc(osc[g]));
    end
    sckpm_top #(.STABLE_TICKS(2)) i_sckpm_top (.I_REF_CLK(clk), .I_RESETN(rstn),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
        .I_AVS_BYTEENABLE(4'h1), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
        .I_HALT(halt), .I_WAKE(wake), .I_WDT_ENABLE(wdt), .I_FAST_RC_OSC(osc[0]),
        .I_FAST_XTAL_OSC(osc[1]), .I_SLOW_XTAL_OSC(osc[2]), .I_SLOW_RC_OSC(osc[3]),
        .O_FAST_RC_ON(on[0]), .O_FAST_RC_FREQ(frq), .O_FAST_XTAL_ON(on[1]),
        .O_FAST_XTAL_RANGE(rng), .O_SLOW_XTAL_ON(on[2]), .O_SLOW_XTAL_SPEEDUP(spd),
        .O_SLOW_RC_ON(on[3]), .O_SYSTEM_CLOCK_EN(sys_en), .O_HIGH_SPEED_CLOCK_EN(),
        .O_LOW_SPEED_CLOCK_EN(), .O_CPU_RUN(cpu), .O_MODE(mode), .O_SWITCH_BUSY(busy));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // waitrequest and read data are both taken at the rising edge that ends the wait
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        rd <= ~w; wr <= w; adr <= a; wd <= {24'h0, d};
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (!wreq) break;
        end
        q = rdata;
        rd <= 1'b0; wr <= 1'b0;
        if (n == 50) begin n_fail++; print_verdict(); end
    endtask : bus
    // one-cycle halt or wake pulse, then look once the mode has moved
    task automatic hw(input logic h);
        @(posedge clk); halt <= h; wake <= ~h;
        @(posedge clk); halt <= 1'b0; wake <= 1'b0;
        @(negedge clk);
    endtask : hw
    initial begin
        {rd, wr, halt, wake, wdt, rstn} = '0; adr = '0; wd = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(0, 3'(i), 8'h0); chk(q, {24'h0, rst_v[i]});
        end
        bus(1, 3'h5, 8'hff); bus(0, 3'h5, 8'h0); chk(q, 32'h0);
        bus(1, OFS_FAST_XTAL, 8'h05); bus(0, OFS_FAST_XTAL, 8'h0); chk(q, 32'h05);
        repeat (100) @(posedge clk);
        // range is frozen while the crystal runs
        bus(1, OFS_FAST_XTAL, 8'h01); bus(0, OFS_FAST_XTAL, 8'h0); chk(q, 32'h07);
        chk(32'(rng), 32'h1);
        bus(1, OFS_FAST_RC, 8'h05); bus(0, OFS_FAST_RC, 8'h0); chk(q, 32'h05);
        chk(32'(frq), 32'h1);
        bus(1, OFS_SLOW_XTAL, 8'h05); bus(0, OFS_SLOW_XTAL, 8'h0); chk(q, 32'h05);
        chk(32'(spd), 32'h1);
        for (int i = 0; i < 4; i++) begin
            bus(1, OFS_SYS_CLK, 8'(i));
            wdt <= (i == 0);
            hw(1); chk(32'(mode), 32'(exp_m[i]));
            chk(32'(cpu), 32'h0);
            repeat (8) @(posedge clk);
            hw(0); chk(32'(mode), 32'(MODE_FAST));
        end
        bus(1, OFS_SYS_CLK, 8'he1);
        for (k = 0; k < 900; k++) begin @(negedge clk); if (k > 2 && busy === 1'b0) break; end
        if (k == 900) begin n_fail++; print_verdict(); end
        chk(32'(mode), 32'(MODE_SLOW));
        hw(1); chk(32'(mode), 32'(MODE_IDLE_LOW));
        k = 0;
        repeat (200) begin @(negedge clk); if (sys_en === 1'b1) k++; end
        chk(32'(k > 0), 32'h1);
        hw(0);
        print_verdict();
    end
endmodule : sckpm_top_test
